// *** hw/iep_consts.svh ***
// Overview of operation
// (RQ1) Global gate overrides every individual mask bit
// (RQ2) Main enable bit 6 masks SPI requests
// (RQ3) Bit 5 gates timer two low/high overflow
// (RQ4) Bit 4 masks the UART request
// (RQ5) Bit 3 gates timer one overflow requests
// (RQ6) Bit 2 gates external input one requests
// (RQ7) Bit 1 gates timer zero overflow requests
// (RQ8) Bit 0 gates external input zero requests
// (RQ9) Level register bit 7 reads one, ignores writes
// (RQ10) Level bits choose high or low per source
// (RQ11) Ext one bit 5 gates comparator rise/fall
// (RQ12) Ext one bit 4 gates ADC done
// (RQ13) Ext one bit 3 masks counter array requests
// (RQ14) Ext one bit 2 gates ADC window compare
// (RQ15) Ext one bit 1 gates port match events
// (RQ16) Ext one bit 0 masks SMBus requests
// (RQ17) Ext two bits 7:2 read zero, ignore writes
// (RQ18) Ext two bit 1 gates capsense greater-than
// (RQ19) Ext two bit 0 gates capsense done
// (RQ20) Main registers at A8/B8, byte and bit access
// (RQ21) High never preempted; low preemptable by high
// (RQ22) Higher level first, then fixed source order
// (RQ23) Reset clears every enable and level bit; the extended source levels come in on ext_irq_level and are not reset here
// (RQ24) Software writes zero to ext one bits 7:6
`ifndef IEP_CONSTS_SVH
`define IEP_CONSTS_SVH
`define IEP_ADDR_MASK_MAIN 8'hA8
`define IEP_ADDR_LEVEL_MAIN 8'hB8
`define IEP_ADDR_MASK_EXT1 8'hE6
`define IEP_ADDR_MASK_EXT2 8'hE7
`define IEP_BIT_GLOBAL 7
`define IEP_LEVEL_TOP_READ 1'h1
`define IEP_EXT1_WMASK 8'h3F
`define IEP_EXT2_WMASK 8'h03
`define IEP_RESET_BYTE 8'h00
`define IEP_NUM_VEC 17
`define IEP_VEC_EXT0 0
`define IEP_VEC_TMR0 1
`define IEP_VEC_EXT1 2
`define IEP_VEC_TMR1 3
`define IEP_VEC_UART 4
`define IEP_VEC_TMR2 5
`define IEP_VEC_SPI 6
`define IEP_VEC_SMB 7
`define IEP_VEC_MATCH 8
`define IEP_VEC_ADCWIN 9
`define IEP_VEC_ADCDONE 10
`define IEP_VEC_PCA 11
`define IEP_VEC_CMP 12
`define IEP_VEC_CSDONE 15
`define IEP_VEC_CSGT 16
`define IEP_BIT_SMB 0
`define IEP_BIT_MATCH 1
`define IEP_BIT_ADCWIN 2
`define IEP_BIT_PCA 3
`define IEP_BIT_ADCDONE 4
`define IEP_BIT_CMP 5
`define IEP_BIT_CSDONE 0
`define IEP_BIT_CSGT 1
`endif

// *** hw/iep_pkg.sv ***
`default_nettype none
package iep_pkg;
   typedef struct packed {
      logic timer_zero_overflow_flag;
      logic timer_one_overflow_flag;
      logic timer_two_low_overflow_flag;
      logic timer_two_high_overflow_flag;
      logic uart_flag;
      logic spi_flag;
      logic smbus_flag;
      logic port_match_flag;
      logic adc_window_flag;
      logic adc_done_flag;
      logic counter_array_flag;
      logic comparator_rise_flag;
      logic comparator_fall_flag;
      logic capsense_done_flag;
      logic capsense_greater_flag;
   } iep_src_t;

   typedef struct packed {
      logic req;
      logic high;
      logic [4:0] idx;
   } iep_grant_t;

   typedef enum logic [1:0] {
      IEP_IDLE,
      IEP_IN_LOW,
      IEP_IN_HIGH,
      IEP_IN_BOTH
   } iep_svc_t;
endpackage
`default_nettype wire

// *** hw/iep_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module iep_sync (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'h0;
         s2_q <= 1'h0;
         s3_q <= 1'h0;
         level <= 1'h0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Change is taken only once two stages agree
         if (s2_q == s3_q) begin
            level <= s3_q;
         end
      end
   end
endmodule
`default_nettype wire

// *** hw/iep_arb.sv ***
`timescale 1ns/1ps
`default_nettype none
module iep_arb (
   input wire logic [16:0] req,
   input wire logic [16:0] level,
   input wire logic allow_low,
   input wire logic allow_high,
   output iep_pkg::iep_grant_t grant
);
   logic [4:0] hi_idx;
   logic [4:0] lo_idx;
   logic [16:0] hi_req;
   logic [16:0] lo_req;

   function automatic logic [4:0] first_set(input logic [16:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 16; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   assign hi_req = req & level & {17{allow_high}};
   assign lo_req = req & ~level & {17{allow_low}};
   assign hi_idx = first_set(hi_req);
   assign lo_idx = first_set(lo_req);

   always_comb begin
      grant = '0;
      if (|hi_req) begin // RQ22
         grant.req = 1'h1;
         grant.high = 1'h1;
         grant.idx = hi_idx;
      end else if (|lo_req) begin
         grant.req = 1'h1;
         grant.idx = lo_idx;
      end
   end
endmodule
`default_nettype wire

// *** hw/iep_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.svh"
module iep_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic [7:0] bit_addr,
   input wire logic bit_wr,
   input wire logic bit_rd,
   input wire logic bit_wdata,
   output logic bit_rdata,
   input wire iep_pkg::iep_src_t src,
   input wire logic ext_irq_pin_zero,
   input wire logic ext_irq_pin_one,
   input wire logic [9:0] ext_irq_level,
   input wire logic irq_ack,
   input wire logic irq_reti,
   output logic irq_req,
   output logic irq_high,
   output logic [4:0] irq_idx,
   output logic [1:0] in_service
);
   logic [7:0] mask_main_q;
   logic [7:0] mask_main_d;
   logic [6:0] level_main_q;
   logic [6:0] level_main_d;
   logic [5:0] mask_ext1_q;
   logic [5:0] mask_ext1_d;
   logic [1:0] mask_ext2_q;
   logic [1:0] mask_ext2_d;
   logic [7:0] rdata_q;
   logic bit_rdata_q;
   logic [7:0] level_read;
   logic [1:0] pin_level;
   logic [1:0] pin_raw;
   logic [16:0] raw_req;
   logic [16:0] enable_vec;
   logic [16:0] gated_req;
   logic [16:0] level_vec;
   logic allow_low;
   logic allow_high;
   iep_pkg::iep_grant_t grant;
   iep_pkg::iep_grant_t grant_q;
   iep_pkg::iep_svc_t svc_q;
   iep_pkg::iep_svc_t svc_d;

   // Bit address is register base plus bit number
   function automatic logic hits(input logic [7:0] a, input logic [7:0] base);
      return a[7:3] == base[7:3];
   endfunction

   function automatic logic [7:0] read_byte(
      input logic [7:0] a,
      input logic [7:0] m_main,
      input logic [6:0] l_main,
      input logic [5:0] m_ext1,
      input logic [1:0] m_ext2
   );
      logic [7:0] r;
      r = 8'h00;
      case (a)
         `IEP_ADDR_MASK_MAIN: begin
            r = m_main;
         end
         `IEP_ADDR_LEVEL_MAIN: begin
            r = {`IEP_LEVEL_TOP_READ, l_main}; // RQ9
         end
         `IEP_ADDR_MASK_EXT1: begin
            r = {2'h0, m_ext1};
         end
         `IEP_ADDR_MASK_EXT2: begin
            r = {6'h00, m_ext2}; // RQ17
         end
         default: begin
            r = 8'h00;
         end
      endcase
      return r;
   endfunction

   // External pins enter the core clock domain through synchronisers
   assign pin_raw = {ext_irq_pin_one, ext_irq_pin_zero};

   generate
      for (genvar g = 0; g < 2; g++) begin : g_pin
         iep_sync u_sync (
            .clock(clock),
            .rst_n(rst_n),
            .pin(pin_raw[g]),
            .level(pin_level[g])
         );
      end
   endgenerate

   // Byte write first, then a bit write to the same byte wins
   always_comb begin
      mask_main_d = mask_main_q;
      level_main_d = level_main_q;
      mask_ext1_d = mask_ext1_q;
      mask_ext2_d = mask_ext2_q;
      if (sfr_wr) begin
         case (sfr_addr)
            `IEP_ADDR_MASK_MAIN: begin
               mask_main_d = sfr_wdata; // RQ20
            end
            `IEP_ADDR_LEVEL_MAIN: begin
               level_main_d = sfr_wdata[6:0]; // RQ9
            end
            `IEP_ADDR_MASK_EXT1: begin
               mask_ext1_d = 6'(sfr_wdata & `IEP_EXT1_WMASK);
            end
            `IEP_ADDR_MASK_EXT2: begin
               mask_ext2_d = 2'(sfr_wdata & `IEP_EXT2_WMASK); // RQ17
            end
            default: begin
               mask_main_d = mask_main_q;
            end
         endcase
      end
      if (bit_wr) begin
         if (hits(bit_addr, `IEP_ADDR_MASK_MAIN)) begin
            mask_main_d[bit_addr[2:0]] = bit_wdata; // RQ20
         end else if (hits(bit_addr, `IEP_ADDR_LEVEL_MAIN) && bit_addr[2:0] != 3'h7) begin
            level_main_d[bit_addr[2:0]] = bit_wdata; // RQ9
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mask_main_q <= `IEP_RESET_BYTE; // RQ23
         level_main_q <= 7'h00;
         mask_ext1_q <= 6'h00;
         mask_ext2_q <= 2'h0;
      end else begin
         mask_main_q <= mask_main_d;
         level_main_q <= level_main_d;
         mask_ext1_q <= mask_ext1_d;
         mask_ext2_q <= mask_ext2_d;
      end
   end

   // Reads return state as it stood before any same-cycle write
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
         bit_rdata_q <= 1'h0;
      end else begin
         if (sfr_rd) begin
            rdata_q <= read_byte(sfr_addr, mask_main_q, level_main_q, mask_ext1_q,
                                 mask_ext2_q);
         end
         if (bit_rd) begin
            if (hits(bit_addr, `IEP_ADDR_MASK_MAIN)) begin
               bit_rdata_q <= mask_main_q[bit_addr[2:0]]; // RQ20
            end else if (hits(bit_addr, `IEP_ADDR_LEVEL_MAIN)) begin
               bit_rdata_q <= level_read[bit_addr[2:0]]; // RQ9
            end else begin
               bit_rdata_q <= 1'h0;
            end
         end
      end
   end

   // Byte view of the level register, so bit reads see the forced top bit
   assign level_read = read_byte(`IEP_ADDR_LEVEL_MAIN, mask_main_q, level_main_q, mask_ext1_q,
                                 mask_ext2_q);
   assign sfr_rdata = rdata_q;
   assign bit_rdata = bit_rdata_q;

   // Source requests in fixed vector order
   always_comb begin
      raw_req = 17'h00000;
      raw_req[`IEP_VEC_EXT0] = pin_level[0];
      raw_req[`IEP_VEC_TMR0] = src.timer_zero_overflow_flag;
      raw_req[`IEP_VEC_EXT1] = pin_level[1];
      raw_req[`IEP_VEC_TMR1] = src.timer_one_overflow_flag;
      raw_req[`IEP_VEC_UART] = src.uart_flag;
      raw_req[`IEP_VEC_TMR2] = src.timer_two_low_overflow_flag
                             | src.timer_two_high_overflow_flag; // RQ3
      raw_req[`IEP_VEC_SPI] = src.spi_flag;
      raw_req[`IEP_VEC_SMB] = src.smbus_flag;
      raw_req[`IEP_VEC_MATCH] = src.port_match_flag;
      raw_req[`IEP_VEC_ADCWIN] = src.adc_window_flag;
      raw_req[`IEP_VEC_ADCDONE] = src.adc_done_flag;
      raw_req[`IEP_VEC_PCA] = src.counter_array_flag;
      raw_req[`IEP_VEC_CMP] = src.comparator_rise_flag
                            | src.comparator_fall_flag; // RQ11
      raw_req[`IEP_VEC_CSDONE] = src.capsense_done_flag;
      raw_req[`IEP_VEC_CSGT] = src.capsense_greater_flag;
   end

   // Ext one bits are not in vector order; ADC done and PCA cross
   always_comb begin
      enable_vec = 17'h00000;
      enable_vec[`IEP_VEC_EXT0] = mask_main_q[0]; // RQ8
      enable_vec[`IEP_VEC_TMR0] = mask_main_q[1]; // RQ7
      enable_vec[`IEP_VEC_EXT1] = mask_main_q[2]; // RQ6
      enable_vec[`IEP_VEC_TMR1] = mask_main_q[3]; // RQ5
      enable_vec[`IEP_VEC_UART] = mask_main_q[4]; // RQ4
      enable_vec[`IEP_VEC_TMR2] = mask_main_q[5]; // RQ3
      enable_vec[`IEP_VEC_SPI] = mask_main_q[6]; // RQ2
      enable_vec[`IEP_VEC_SMB] = mask_ext1_q[`IEP_BIT_SMB]; // RQ16
      enable_vec[`IEP_VEC_MATCH] = mask_ext1_q[`IEP_BIT_MATCH]; // RQ15
      enable_vec[`IEP_VEC_ADCWIN] = mask_ext1_q[`IEP_BIT_ADCWIN]; // RQ14
      enable_vec[`IEP_VEC_ADCDONE] = mask_ext1_q[`IEP_BIT_ADCDONE]; // RQ12
      enable_vec[`IEP_VEC_PCA] = mask_ext1_q[`IEP_BIT_PCA]; // RQ13
      enable_vec[`IEP_VEC_CMP] = mask_ext1_q[`IEP_BIT_CMP]; // RQ11
      enable_vec[`IEP_VEC_CSDONE] = mask_ext2_q[`IEP_BIT_CSDONE]; // RQ19
      enable_vec[`IEP_VEC_CSGT] = mask_ext2_q[`IEP_BIT_CSGT]; // RQ18
   end

   assign gated_req = raw_req & enable_vec
                    & {17{mask_main_q[`IEP_BIT_GLOBAL]}}; // RQ1

   // Extended sources take their level from outside
   assign level_vec = {ext_irq_level, level_main_q}; // RQ10

   // High in service blocks all; low in service admits only high
   always_comb begin
      allow_low = 1'h0;
      allow_high = 1'h0;
      case (svc_q)
         iep_pkg::IEP_IDLE: begin
            allow_low = 1'h1;
            allow_high = 1'h1;
         end
         iep_pkg::IEP_IN_LOW: begin
            allow_high = 1'h1; // RQ21
         end
         default: begin
            allow_low = 1'h0; // RQ21
         end
      endcase
   end

   iep_arb u_arb (
      .req(gated_req),
      .level(level_vec),
      .allow_low(allow_low),
      .allow_high(allow_high),
      .grant(grant)
   );

   // Return pops the most recent level before a new grant is taken
   always_comb begin
      svc_d = svc_q;
      case (svc_q)
         iep_pkg::IEP_IDLE: begin
            if (irq_ack && grant_q.req) begin
               svc_d = grant_q.high ? iep_pkg::IEP_IN_HIGH : iep_pkg::IEP_IN_LOW;
            end
         end
         iep_pkg::IEP_IN_LOW: begin
            if (irq_reti) begin
               svc_d = iep_pkg::IEP_IDLE;
            end else if (irq_ack && grant_q.req && grant_q.high) begin
               svc_d = iep_pkg::IEP_IN_BOTH; // RQ21
            end
         end
         iep_pkg::IEP_IN_HIGH: begin
            if (irq_reti) begin
               svc_d = iep_pkg::IEP_IDLE;
            end
         end
         iep_pkg::IEP_IN_BOTH: begin
            if (irq_reti) begin
               svc_d = iep_pkg::IEP_IN_LOW;
            end
         end
         default: begin
            svc_d = iep_pkg::IEP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         svc_q <= iep_pkg::IEP_IDLE;
      end else begin
         svc_q <= svc_d;
      end
   end

   // Decoded once per cycle; dropped on ack so one grant is not taken twice
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         grant_q <= '0;
      end else if (irq_ack || irq_reti) begin
         grant_q <= '0;
      end else begin
         grant_q <= grant; // RQ22
      end
   end

   assign irq_req = grant_q.req;
   assign irq_high = grant_q.high;
   assign irq_idx = grant_q.idx;
   assign in_service = svc_q;
endmodule
`default_nettype wire

// *** testbench/iep_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module iep_properties (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic [7:0] bit_addr,
   input wire logic bit_wr,
   input wire logic bit_wdata,
   input wire logic irq_ack,
   input wire logic irq_reti,
   input wire logic irq_req,
   input wire logic irq_high,
   input wire logic [1:0] in_service
);
   // Mirror of the global gate only, bit access wins
   logic gate_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gate_q <= 1'b0;
      end else if (bit_wr && bit_addr == 8'hAF) begin
         gate_q <= bit_wdata;
      end else if (sfr_wr && sfr_addr == 8'hA8) begin
         gate_q <= sfr_wdata[7];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   rst_clear_a: assert property ($rose(rst_n) |-> !irq_req && in_service == 2'h0)
      else $error("outputs not idle after reset");
   level_top_a: assert property (sfr_rd && sfr_addr == 8'hB8 |=> sfr_rdata[7])
      else $error("level register top bit not one");
   ext_two_zero_a: assert property (sfr_rd && sfr_addr == 8'hE7 |=> sfr_rdata[7:2] == 6'h00)
      else $error("ext two unused bits not zero");
   mask_readback_a: assert property ((sfr_wr && sfr_addr == 8'hA8 && !bit_wr) ##1
      (!sfr_wr && !bit_wr) ##1 (sfr_rd && sfr_addr == 8'hA8 && !sfr_wr && !bit_wr)
      |=> sfr_rdata == $past(sfr_wdata, 3))
      else $error("main mask readback differs");
   gate_off_a: assert property (!gate_q |=> !irq_req)
      else $error("request with global gate off");
   high_hold_a: assert property (in_service[1] |-> !irq_req)
      else $error("request during high service");
   low_only_a: assert property (in_service == 2'h1 && irq_req |-> irq_high)
      else $error("low request during low service");
   preempt_low_a: assert property (irq_ack && irq_req && irq_high && !irq_reti
      && in_service == 2'h1 |=> in_service == 2'h3)
      else $error("high did not preempt low");
   reti_pop_a: assert property (irq_reti && !irq_ack && in_service == 2'h3
      |=> in_service == 2'h1)
      else $error("return did not resume low");
   cover property (irq_ack && irq_high && in_service == 2'h1);
   cover property (irq_reti && in_service == 2'h3);
   cover property (gate_q && irq_req && !irq_high);
   cover property (in_service == 2'h2 && !irq_req);
endmodule
bind iep_top iep_properties i_props (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wdata(bit_wdata), .irq_ack(irq_ack),
   .irq_reti(irq_reti), .irq_req(irq_req), .irq_high(irq_high), .in_service(in_service));
`default_nettype wire

// *** testbench/iep_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module iep_cpu_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic irq_req,
   input wire logic ack_en,
   input wire logic [3:0] lag,
   input wire logic ret_go,
   output logic irq_ack,
   output logic irq_reti
);
   logic [3:0] wait_q;
   // One ack per presented request, after lag cycles
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 4'h0;
         irq_ack <= 1'b0;
      end else begin
         irq_ack <= 1'b0;
         if (irq_req && ack_en && !irq_ack) begin
            wait_q <= (wait_q >= lag) ? 4'h0 : wait_q + 4'h1;
            irq_ack <= (wait_q >= lag);
         end
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_reti <= 1'b0;
      end else begin
         irq_reti <= ret_go;
      end
   end
endmodule
`default_nettype wire

// *** testbench/test_interrupt_enable_priority_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_enable_priority_regs;
   logic clock, rst_n, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, bit_rdata;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bit_addr, seen;
   logic pin0, pin1, irq_ack, irq_reti, irq_req, irq_high, ack_en, ret_go;
   logic [9:0] lvl;
   logic [3:0] lag;
   logic [4:0] irq_idx;
   logic [1:0] in_service;
   iep_pkg::iep_src_t src;
   logic [31:0] seed = 32'h00002B7F;
   int num_errors = 0;
   int samples_checked = 0;
   // {address, mask bit, vector}, indexed by {pin1, pin0, src} bit
   logic [15:0] tab [0:16] = '{16'hE730, 16'hE70F, 16'hE6AC, 16'hE6AC, 16'hE66B, 16'hE68A,
      16'hE649, 16'hE628, 16'hE607, 16'hA8C6, 16'hA884, 16'hA8A5, 16'hA8A5, 16'hA863,
      16'hA821, 16'hA800, 16'hA842};
   logic [7:0] ad [0:4] = '{8'hA8, 8'hB8, 8'hE6, 8'hE7, 8'hC0};
   logic [7:0] wm [0:4] = '{8'h7F, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
   logic [7:0] rm [0:4] = '{8'hFF, 8'h7F, 8'h3F, 8'h03, 8'h00};
   logic [7:0] om [0:4] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
   assign seen = {irq_high, irq_req, 1'b0, irq_idx};
   iep_top i_dut (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_addr(bit_addr),
      .bit_wr(bit_wr), .bit_rd(bit_rd), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata),
      .src(src), .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1), .ext_irq_level(lvl),
      .irq_ack(irq_ack), .irq_reti(irq_reti), .irq_req(irq_req), .irq_high(irq_high),
      .irq_idx(irq_idx), .in_service(in_service));
   iep_cpu_model i_cpu (.clock(clock), .rst_n(rst_n), .irq_req(irq_req), .ack_en(ack_en),
      .lag(lag), .ret_go(ret_go), .irq_ack(irq_ack), .irq_reti(irq_reti));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic exp_high(input logic [4:0] x);
      return (x >= 5'h07) ? lvl[x - 5'h07] : 1'b0;
   endfunction
   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      step(1);
      sfr_wr <= 1'b0;
      step(1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      step(1);
      sfr_rd <= 1'b0;
      step(1);
      d = sfr_rdata;
   endtask
   task automatic bwr(input logic [7:0] a, input logic v);
      bit_addr <= a;
      bit_wdata <= v;
      bit_wr <= 1'b1;
      step(1);
      bit_wr <= 1'b0;
      step(1);
   endtask
   task automatic brd(input logic [7:0] a, output logic v);
      bit_addr <= a;
      bit_rd <= 1'b1;
      step(1);
      bit_rd <= 1'b0;
      step(1);
      v = bit_rdata;
   endtask
   // Only the chosen register gets the bit, reserved bits stay zero
   task automatic put(input logic [7:0] a, input logic [2:0] b, input logic g, input logic m);
      logic [7:0] k;
      k = {7'h00, m} << b;
      wr(8'hA8, {g, (a == 8'hA8) ? k[6:0] : 7'h00});
      wr(8'hE6, (a == 8'hE6) ? k : 8'h00);
      wr(8'hE7, (a == 8'hE7) ? k : 8'h00);
   endtask
   task automatic drive(input logic [16:0] v);
      src <= iep_pkg::iep_src_t'(v[14:0]);
      pin0 <= v[15];
      pin1 <= v[16];
   endtask
   task automatic wait_svc(input logic [1:0] s);
      int n;
      n = 0;
      while (in_service !== s && n < 60) begin
         step(1);
         n++;
      end
      chk({6'h00, in_service}, {6'h00, s}, "service state");
      if (n == 60) begin
         close_out();
      end
   endtask
   task automatic reti();
      ret_go <= 1'b1;
      step(1);
      ret_go <= 1'b0;
   endtask
   initial begin : main
      logic [7:0] d, e;
      logic [31:0] r;
      logic [15:0] t;
      logic v;
      rst_n = 1'b0;
      {sfr_addr, sfr_wdata, bit_addr, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata} = '0;
      {pin0, pin1, ack_en, ret_go, lag, lvl} = '0;
      src = '0;
      step(8);
      rst_n <= 1'b1;
      step(1);
      for (int i = 0; i < 5; i++) begin
         rd(ad[i], d);
         chk(d, om[i], "reset value");
         r = rnd();
         e = r[7:0] & wm[i];
         wr(ad[i], e);
         rd(ad[i], d);
         chk(d, (e & rm[i]) | om[i], "readback");
      end
      $display("register test done");
      for (int b = 0; b < 2; b++) begin
         e = b ? 8'h80 : 8'h00;
         for (int n = 0; n < 8; n++) begin
            r = rnd();
            bwr(8'hA8 + 8'(16 * b + n), r[0]);
            if (b == 0 || n < 7) e[n] = r[0];
         end
         rd(8'hA8 + 8'(16 * b), d);
         chk(d, e, "bit writes");
         for (int n = 0; n < 8; n++) begin
            brd(8'hA8 + 8'(16 * b + n), v);
            chk({7'h00, v}, {7'h00, e[n]}, "bit read");
         end
      end
      $display("bit access test done");
      wr(8'hB8, 8'h00);
      for (int i = 0; i < 17; i++) begin
         t = tab[i];
         r = rnd();
         lvl <= r[9:0];
         put(t[15:8], t[7:5], 1'b0, 1'b1);
         drive(17'h00001 << i);
         step(6);
         chk({7'h00, irq_req}, 8'h00, "gate off");
         put(t[15:8], t[7:5], 1'b1, 1'b1);
         step(6);
         chk(seen, {exp_high(t[4:0]), 2'b10, t[4:0]}, "source");
         put(t[15:8], t[7:5], 1'b1, 1'b0);
         step(6);
         chk({7'h00, irq_req}, 8'h00, "masked");
         drive(17'h00000);
      end
      $display("source gating test done");
      lvl <= 10'h000;
      wr(8'hA8, 8'h92);
      wr(8'hB8, 8'h10);
      drive(17'h04400);
      step(3);
      chk(seen, 8'hC4, "high first");
      wr(8'hB8, 8'h00);
      step(3);
      chk(seen, 8'h41, "fixed order");
      drive(17'h04000);
      r = rnd();
      lag <= r[3:0];
      ack_en <= 1'b1;
      wait_svc(2'h1);
      wr(8'hB8, 8'h10);
      drive(17'h04400);
      wait_svc(2'h3);
      ack_en <= 1'b0;
      step(4);
      chk({7'h00, irq_req}, 8'h00, "high not preempted");
      reti();
      wait_svc(2'h1);
      step(3);
      chk(seen, 8'hC4, "high over low");
      reti();
      wait_svc(2'h0);
      ack_en <= 1'b1;
      wait_svc(2'h2);
      ack_en <= 1'b0;
      step(4);
      chk({7'h00, irq_req}, 8'h00, "high blocks low");
      reti();
      wait_svc(2'h0);
      drive(17'h00000);
      $display("priority test done");
      close_out();
   end
endmodule
`default_nettype wire
